// File: logic/csfam_core.sv
// Purpose: status flags, arithmetic write-back steering and address map of the core
// Assumes: bus strobes one cycle, never both; peripheral read data valid in the read cycle
// Notes: rom is loaded over the bus while prog_en_i is high; boot starts when it drops
`timescale 1ns/1ps
module csfam_core (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	input  wire csfam_pkg::csfam_ram_t ram_size_i,
	input  wire csfam_pkg::csfam_rom_t rom_size_i,
	input  wire logic                 vec_large_i,
	input  wire logic                 prog_en_i,
	input  wire csfam_pkg::csfam_bus_t bus_i,
	input  wire logic [7:0]           periph_rdata_i,
	input  wire csfam_pkg::csfam_req_t op_i,
	output logic [7:0]                bus_rdata_o,
	output csfam_pkg::csfam_region_t  bus_region_o,
	output csfam_pkg::csfam_peri_t    periph_o,
	output csfam_pkg::csfam_res_t     res_o,
	output logic [7:0]                ps_o,
	output logic [15:0]               pc_o,
	output logic                      pc_vld_o
);
	localparam csfam_pkg::csfam_state_t STATE_RST = '{
		fsm: csfam_pkg::ST_WAIT,
		ps: csfam_pkg::PS_RST,
		default: '0
	};

	csfam_pkg::csfam_state_t  s_q;
	csfam_pkg::csfam_state_t  s_d;
	csfam_pkg::csfam_region_t region;
	logic [7:0]               ram_mem [csfam_pkg::RAM_DEPTH];
	logic [7:0]               rom_mem [csfam_pkg::ROM_DEPTH];
	logic                     ram_we;
	logic                     rom_we;
	logic [7:0]               lhs;
	logic [9:0]               sum;
	logic [7:0]               res;
	logic                     wr_res;
	logic [17:0]              ea_len;

	// rom index works for every size since all rom ends at the top
	function automatic logic [13:0] rom_idx(input logic [15:0] addr);
		return addr[13:0];
	endfunction : rom_idx

	function automatic logic [8:0] ram_idx(input logic [15:0] addr);
		return addr[8:0];
	endfunction : ram_idx

	// returns {carry, overflow, result}
	function automatic logic [9:0] alu_addsub(
		input logic [7:0] lhs_a,
		input logic [7:0] rhs_a,
		input logic       cin,
		input logic       sub,
		input logic       dec
	);
		logic [7:0] opd;
		logic [8:0] uns;
		int         sgn;
		logic [4:0] lo;
		logic [4:0] hi;
		logic [7:0] r;
		logic       cout;
		logic       ovf;
		opd = sub ? ~rhs_a : rhs_a;
		uns = {1'b0, lhs_a} + {1'b0, opd} + {8'h00, cin};
		if (sub)
		begin
			sgn = int'($signed(lhs_a)) - int'($signed(rhs_a)) - int'(!cin);
		end
		else
		begin
			sgn = int'($signed(lhs_a)) + int'($signed(rhs_a)) + int'(cin);
		end
		ovf = (sgn > csfam_pkg::SGN_MAX) || (sgn < csfam_pkg::SGN_MIN);
		r = uns[7:0];
		cout = uns[8];
		lo = 5'h00;
		hi = 5'h00;
		// decimal keeps the binary overflow; it is meaningless there
		if (dec && !sub)
		begin
			lo = {1'b0, lhs_a[3:0]} + {1'b0, rhs_a[3:0]} + {4'h0, cin};
			if (lo > csfam_pkg::BCD_MAX)
			begin
				lo = lo + csfam_pkg::BCD_ADJ;
			end
			hi = {1'b0, lhs_a[7:4]} + {1'b0, rhs_a[7:4]} + {4'h0, lo[4]};
			if (hi > csfam_pkg::BCD_MAX)
			begin
				hi = hi + csfam_pkg::BCD_ADJ;
			end
			r = {hi[3:0], lo[3:0]};
			cout = hi[4];
		end
		else if (dec)
		begin
			lo = {1'b0, lhs_a[3:0]} - {1'b0, rhs_a[3:0]} - {4'h0, !cin};
			if (lo[4])
			begin
				lo = lo - csfam_pkg::BCD_ADJ;
			end
			hi = {1'b0, lhs_a[7:4]} - {1'b0, rhs_a[7:4]} - {4'h0, lo[4]};
			if (hi[4])
			begin
				hi = hi - csfam_pkg::BCD_ADJ;
			end
			r = {hi[3:0], lo[3:0]};
			cout = !hi[4];
		end
		return {cout, ovf, r};
	endfunction : alu_addsub

	// returns {length, effective address}
	function automatic logic [17:0] eff_addr(
		input csfam_pkg::csfam_amode_t amode,
		input logic [7:0]              lo_b,
		input logic [7:0]              hi_b
	);
		logic [17:0] r;
		case (amode)
			csfam_pkg::AM_ZP: r = {csfam_pkg::LEN_2, csfam_pkg::ZP_PAGE, lo_b};
			csfam_pkg::AM_ZPBR: r = {csfam_pkg::LEN_3, csfam_pkg::ZP_PAGE, lo_b};
			csfam_pkg::AM_SPEC: r = {csfam_pkg::LEN_2, csfam_pkg::SP_PAGE, lo_b};
			default: r = {csfam_pkg::LEN_3, hi_b, lo_b};
		endcase
		return r;
	endfunction : eff_addr

	csfam_addr_dec u_dec (
		.addr_i      (bus_i.addr),
		.ram_size_i  (ram_size_i),
		.rom_size_i  (rom_size_i),
		.vec_large_i (vec_large_i),
		.region_o    (region)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.res.vld = 1'b0;
		s_d.periph.wr = 1'b0;
		ram_we = 1'b0;
		rom_we = 1'b0;
		wr_res = 1'b0;
		res = 8'h00;
		lhs = s_q.ps[csfam_pkg::PS_T] ? op_i.m1 : op_i.acc;
		sum = alu_addsub(lhs, op_i.m2, s_q.ps[csfam_pkg::PS_C],
			op_i.op == csfam_pkg::OP_SUB, s_q.ps[csfam_pkg::PS_D]);
		ea_len = eff_addr(op_i.amode, op_i.oper_lo, op_i.oper_hi);

		// boot: fetch the reset vector once rom loading is over
		case (s_q.fsm)
			csfam_pkg::ST_WAIT:
			begin
				if (!prog_en_i)
				begin
					s_d.fsm = csfam_pkg::ST_LO;
				end
			end
			csfam_pkg::ST_LO:
			begin
				s_d.pc[7:0] = rom_mem[rom_idx(csfam_pkg::RSTV_LO)];
				s_d.fsm = csfam_pkg::ST_HI;
			end
			csfam_pkg::ST_HI:
			begin
				s_d.pc[15:8] = rom_mem[rom_idx(csfam_pkg::RSTV_HI)];
				s_d.pc_vld = 1'b1;
				s_d.fsm = csfam_pkg::ST_RUN;
			end
			csfam_pkg::ST_RUN:
			begin
				s_d.fsm = csfam_pkg::ST_RUN;
			end
			default:
			begin
				s_d.fsm = csfam_pkg::ST_WAIT;
			end
		endcase

		// one map for memory and registers alike
		if (bus_i.wr || bus_i.rd)
		begin
			s_d.region = region;
		end
		if (bus_i.wr)
		begin
			if (region.periph)
			begin
				s_d.periph.wr = 1'b1;
				s_d.periph.addr = bus_i.addr[csfam_pkg::PERI_AW-1:0];
				s_d.periph.wdata = bus_i.wdata;
			end
			else if (region.ram)
			begin
				ram_we = 1'b1;
			end
			else if (region.rom)
			begin
				rom_we = prog_en_i;
			end
			// anything else is dropped
		end
		else if (bus_i.rd)
		begin
			if (region.periph)
			begin
				s_d.rdata = periph_rdata_i;
			end
			else if (region.ram)
			begin
				s_d.rdata = ram_mem[ram_idx(bus_i.addr)];
			end
			else if (region.rom)
			begin
				s_d.rdata = rom_mem[rom_idx(bus_i.addr)];
			end
			else
			begin
				s_d.rdata = csfam_pkg::UNMAP_RD;
			end
		end

		if (op_i.vld)
		begin
			case (op_i.op)
				csfam_pkg::OP_ADD, csfam_pkg::OP_SUB:
				begin
					res = sum[7:0];
					wr_res = 1'b1;
					s_d.ps[csfam_pkg::PS_C] = sum[9];
					s_d.ps[csfam_pkg::PS_V] = sum[8];
				end
				csfam_pkg::OP_AND:
				begin
					res = lhs & op_i.m2;
					wr_res = 1'b1;
				end
				csfam_pkg::OP_ORA:
				begin
					res = lhs | op_i.m2;
					wr_res = 1'b1;
				end
				csfam_pkg::OP_EOR:
				begin
					res = lhs ^ op_i.m2;
					wr_res = 1'b1;
				end
				csfam_pkg::OP_MOV:
				begin
					res = op_i.m2;
					wr_res = 1'b1;
				end
				csfam_pkg::OP_TST:
				begin
					s_d.ps[csfam_pkg::PS_V] = op_i.m2[6];
					s_d.ps[csfam_pkg::PS_N] = op_i.m2[7];
					s_d.ps[csfam_pkg::PS_Z] = (op_i.acc & op_i.m2) == 8'h00;
				end
				csfam_pkg::OP_SET_T:
				begin
					s_d.ps[csfam_pkg::PS_T] = 1'b1;
				end
				csfam_pkg::OP_CLR_T:
				begin
					s_d.ps[csfam_pkg::PS_T] = 1'b0;
				end
				csfam_pkg::OP_CLR_V:
				begin
					s_d.ps[csfam_pkg::PS_V] = 1'b0;
				end
				csfam_pkg::OP_SET_C:
				begin
					s_d.ps[csfam_pkg::PS_C] = 1'b1;
				end
				csfam_pkg::OP_CLR_C:
				begin
					s_d.ps[csfam_pkg::PS_C] = 1'b0;
				end
				csfam_pkg::OP_SET_D:
				begin
					s_d.ps[csfam_pkg::PS_D] = 1'b1;
				end
				csfam_pkg::OP_CLR_D:
				begin
					s_d.ps[csfam_pkg::PS_D] = 1'b0;
				end
				csfam_pkg::OP_SET_I:
				begin
					s_d.ps[csfam_pkg::PS_I] = 1'b1;
				end
				default:
				begin
					s_d.ps[csfam_pkg::PS_I] = 1'b0;
				end
			endcase
			if (wr_res)
			begin
				// negative is written from results here, and directly from m2 bit 7 by the test op
				s_d.ps[csfam_pkg::PS_N] = res[7];
				s_d.ps[csfam_pkg::PS_Z] = res == 8'h00;
				s_d.res.to_mem = s_q.ps[csfam_pkg::PS_T];
				s_d.res.waddr = s_q.ps[csfam_pkg::PS_T] ?
					{csfam_pkg::ZP_PAGE, op_i.x} : 16'h0000;
				s_d.res.data = res;
			end
			s_d.res.vld = 1'b1;
			s_d.res.ilen = ea_len[17:16];
			s_d.res.ea = ea_len[15:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s_q <= STATE_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// arrays carry no reset; contents after power-up are unknown
	always_ff @(posedge clk_sys_i)
	begin
		if (ram_we)
		begin
			ram_mem[ram_idx(bus_i.addr)] <= bus_i.wdata;
		end
		if (rom_we)
		begin
			rom_mem[rom_idx(bus_i.addr)] <= bus_i.wdata;
		end
	end

	assign bus_rdata_o = s_q.rdata;
	assign bus_region_o = s_q.region;
	assign periph_o = s_q.periph;
	assign res_o = s_q.res;
	assign ps_o = s_q.ps;
	assign pc_o = s_q.pc;
	assign pc_vld_o = s_q.pc_vld;
endmodule : csfam_core

// File: logic/csfam_pkg.sv
// Purpose: shared constants and types for the status flag and address map core
// Assumes: 8-bit data, 16-bit address space, one clock
// Notes: one-hot boot states; op codes are a plain 4-bit encoding
package csfam_pkg;
	localparam int RAM_DEPTH = 512;
	localparam int ROM_DEPTH = 16384;
	localparam int PERI_AW = 6;

	// status bit positions
	localparam int PS_C = 0;
	localparam int PS_Z = 1;
	localparam int PS_I = 2;
	localparam int PS_D = 3;
	localparam int PS_B = 4;
	localparam int PS_T = 5;
	localparam int PS_V = 6;
	localparam int PS_N = 7;
	localparam logic [7:0] PS_RST = 8'h04;

	localparam logic [15:0] ZP_HI = 16'h00FF;
	localparam logic [15:0] SP_LO = 16'hFF00;
	localparam logic [15:0] PERI_LO = 16'h00C0;
	localparam logic [15:0] PERI_HI = 16'h00FF;
	localparam logic [15:0] RAM128_HI = 16'h007F;
	localparam logic [15:0] RAM192_HI = 16'h00BF;
	localparam logic [15:0] RAMP1_LO = 16'h0100;
	localparam logic [15:0] RAMP1_HI = 16'h01BF;
	localparam logic [15:0] ROM4K_LO = 16'hF000;
	localparam logic [15:0] ROM8K_LO = 16'hE000;
	localparam logic [15:0] ROM16K_LO = 16'hC000;
	localparam logic [15:0] VEC_SML_LO = 16'hFFEA;
	localparam logic [15:0] VEC_LRG_LO = 16'hFFE8;
	localparam logic [15:0] RSTV_LO = 16'hFFFE;
	localparam logic [15:0] RSTV_HI = 16'hFFFF;
	localparam logic [7:0] ZP_PAGE = 8'h00;
	localparam logic [7:0] SP_PAGE = 8'hFF;
	localparam logic [7:0] UNMAP_RD = 8'h00;

	localparam int SGN_MAX = 127;
	localparam int SGN_MIN = -128;
	localparam logic [4:0] BCD_MAX = 5'h09;
	localparam logic [4:0] BCD_ADJ = 5'h06;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	typedef enum logic [1:0] {RAM_128 = 2'h0, RAM_192 = 2'h1, RAM_384 = 2'h2} csfam_ram_t;
	typedef enum logic [1:0] {ROM_4K = 2'h0, ROM_8K = 2'h1, ROM_16K = 2'h2} csfam_rom_t;
	typedef enum logic [1:0] {AM_ZP = 2'h0, AM_ZPBR = 2'h1, AM_SPEC = 2'h2, AM_ABS = 2'h3}
		csfam_amode_t;
	typedef enum logic [3:0] {
		OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_ORA = 4'h3,
		OP_EOR = 4'h4, OP_MOV = 4'h5, OP_TST = 4'h6, OP_SET_T = 4'h7,
		OP_CLR_T = 4'h8, OP_CLR_V = 4'h9, OP_SET_C = 4'hA, OP_CLR_C = 4'hB,
		OP_SET_D = 4'hC, OP_CLR_D = 4'hD, OP_SET_I = 4'hE, OP_CLR_I = 4'hF
	} csfam_op_t;
	typedef enum logic [3:0] {ST_WAIT = 4'h1, ST_LO = 4'h2, ST_HI = 4'h4, ST_RUN = 4'h8}
		csfam_fsm_t;

	typedef struct packed {
		logic zero_pg;
		logic special_pg;
		logic ram;
		logic rom;
		logic periph;
		logic vector;
		logic unmapped;
	} csfam_region_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} csfam_bus_t;

	typedef struct packed {
		logic               wr;
		logic [PERI_AW-1:0] addr;
		logic [7:0]         wdata;
	} csfam_peri_t;

	typedef struct packed {
		logic         vld;
		csfam_op_t    op;
		csfam_amode_t amode;
		logic [7:0]   acc;
		logic [7:0]   m1;
		logic [7:0]   m2;
		logic [7:0]   x;
		logic [7:0]   oper_lo;
		logic [7:0]   oper_hi;
	} csfam_req_t;

	typedef struct packed {
		logic        vld;
		logic        to_mem;
		logic [7:0]  data;
		logic [15:0] waddr;
		logic [15:0] ea;
		logic [1:0]  ilen;
	} csfam_res_t;

	typedef struct packed {
		csfam_fsm_t    fsm;
		logic [7:0]    ps;
		logic [15:0]   pc;
		logic          pc_vld;
		logic [7:0]    rdata;
		csfam_region_t region;
		csfam_peri_t   periph;
		csfam_res_t    res;
	} csfam_state_t;
endpackage : csfam_pkg

// File: logic/csfam_addr_dec.sv
// Purpose: decode a 16-bit address into the regions of the map
// Assumes: size selects are stable while in use
// Notes: purely combinational
`timescale 1ns/1ps
module csfam_addr_dec (
	input  wire logic [15:0]          addr_i,
	input  wire csfam_pkg::csfam_ram_t ram_size_i,
	input  wire csfam_pkg::csfam_rom_t rom_size_i,
	input  wire logic                 vec_large_i,
	output csfam_pkg::csfam_region_t  region_o
);
	logic [15:0] rom_lo;
	logic [15:0] vec_lo;
	logic        ram_hit;
	logic        peri_hit;

	always_comb
	begin
		case (rom_size_i)
			csfam_pkg::ROM_4K: rom_lo = csfam_pkg::ROM4K_LO;
			csfam_pkg::ROM_8K: rom_lo = csfam_pkg::ROM8K_LO;
			default: rom_lo = csfam_pkg::ROM16K_LO;
		endcase
		vec_lo = vec_large_i ? csfam_pkg::VEC_LRG_LO : csfam_pkg::VEC_SML_LO;
		case (ram_size_i)
			csfam_pkg::RAM_128: ram_hit = addr_i <= csfam_pkg::RAM128_HI;
			csfam_pkg::RAM_192: ram_hit = addr_i <= csfam_pkg::RAM192_HI;
			default: ram_hit = (addr_i <= csfam_pkg::RAM192_HI) ||
				((addr_i >= csfam_pkg::RAMP1_LO) && (addr_i <= csfam_pkg::RAMP1_HI));
		endcase
		peri_hit = (addr_i >= csfam_pkg::PERI_LO) && (addr_i <= csfam_pkg::PERI_HI);
		region_o.zero_pg = addr_i <= csfam_pkg::ZP_HI;
		region_o.special_pg = addr_i >= csfam_pkg::SP_LO;
		region_o.ram = ram_hit;
		region_o.rom = addr_i >= rom_lo;
		region_o.periph = peri_hit;
		region_o.vector = addr_i >= vec_lo;
		region_o.unmapped = !(ram_hit || peri_hit || (addr_i >= rom_lo));
	end
endmodule : csfam_addr_dec

// File: sim/csfam_props.sv
// Purpose: port checker for the status flag and address map core
// Assumes: one clock, active low reset
// Notes: bound to every core instance
`timescale 1ns/1ps
module csfam_props (
	input wire logic                     clk_sys_i,
	input wire logic                     rstn_i,
	input wire csfam_pkg::csfam_bus_t    bus_i,
	input wire csfam_pkg::csfam_req_t    op_i,
	input wire csfam_pkg::csfam_peri_t   periph_o,
	input wire csfam_pkg::csfam_res_t    res_o,
	input wire logic [7:0]               ps_o
);
	wire logic [7:0] lhs = ps_o[5] ? op_i.m1 : op_i.acc;
	wire logic       dp = op_i.vld && op_i.op <= csfam_pkg::OP_MOV;
	// 00c0..00ff is exactly addr[15:6] == 3
	wire logic       pw = bus_i.wr && bus_i.addr[15:6] == 10'h003;
	wire logic       vt = op_i.vld && op_i.op inside {csfam_pkg::OP_ADD, csfam_pkg::OP_SUB,
		csfam_pkg::OP_TST};
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	property p_dst;
		dp |=> res_o.vld && res_o.to_mem == $past(ps_o[5])
			&& res_o.waddr == ($past(ps_o[5]) ? {8'h00, $past(op_i.x)} : 16'h0000);
	endproperty
	a_dst: assert property (p_dst) else $error("write-back wrong");
	property p_tfl;
		op_i.vld && op_i.op inside {csfam_pkg::OP_SET_T, csfam_pkg::OP_CLR_T}
			|=> ps_o[5] == ($past(op_i.op) == csfam_pkg::OP_SET_T);
	endproperty
	a_tfl: assert property (p_tfl) else $error("direct mode flag wrong");
	property p_ovf;
		op_i.vld && op_i.op == csfam_pkg::OP_ADD && !ps_o[3]
			|=> ps_o[6] == ($past(lhs[7]) == $past(op_i.m2[7]) && res_o.data[7] != $past(lhs[7]));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow wrong");
	property p_tst;
		op_i.vld && op_i.op == csfam_pkg::OP_TST |=> ps_o[7:6] == $past(op_i.m2[7:6]);
	endproperty
	a_tst: assert property (p_tst) else $error("test flags wrong");
	property p_vclr;
		op_i.vld && op_i.op == csfam_pkg::OP_CLR_V |=> !ps_o[6];
	endproperty
	a_vclr: assert property (p_vclr) else $error("overflow not cleared");
	property p_vhold;
		!ps_o[6] && !vt |=> !ps_o[6];
	endproperty
	a_vhold: assert property (p_vhold) else $error("overflow set");
	property p_neg;
		dp && !ps_o[3] |=> ps_o[7] == res_o.data[7];
	endproperty
	a_neg: assert property (p_neg) else $error("negative wrong");
	property p_peri;
		pw |=> periph_o.wr && periph_o.addr == $past(bus_i.addr[5:0])
			&& periph_o.wdata == $past(bus_i.wdata);
	endproperty
	a_peri: assert property (p_peri) else $error("peripheral write lost");
	property p_nperi;
		!pw |=> !periph_o.wr;
	endproperty
	a_nperi: assert property (p_nperi) else $error("stray peripheral write");
	c_ovf: cover property (op_i.vld && op_i.op == csfam_pkg::OP_ADD ##1 ps_o[6]);
	c_tst: cover property (op_i.vld && op_i.op == csfam_pkg::OP_TST && op_i.m2[6]);
	c_peri: cover property (pw);
endmodule : csfam_props
bind csfam_core csfam_props csfam_props_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
	.bus_i(bus_i), .op_i(op_i), .periph_o(periph_o), .res_o(res_o), .ps_o(ps_o));

// File: sim/csfam_periph_model.sv
// Purpose: far side peripheral register area
// Assumes: core samples read data in the read cycle
// Notes: 64 plain bytes, reads have no side effect
`timescale 1ns/1ps
module csfam_periph_model (
	input  wire logic                   clk_sys_i,
	input  wire csfam_pkg::csfam_bus_t  bus_i,
	input  wire csfam_pkg::csfam_peri_t periph_o,
	output logic [7:0]                  periph_rdata_o
);
	logic [7:0] regs [64];
	logic [7:0] last_q = 8'h5A;
	always_ff @(posedge clk_sys_i)
	begin
		if (periph_o.wr)
			regs[periph_o.addr] <= periph_o.wdata;
		if (bus_i.rd)
			last_q <= periph_rdata_o;
	end
	// off a read show garbage, so a stale byte cannot pass
	assign periph_rdata_o = bus_i.rd ? regs[bus_i.addr[5:0]] : ~last_q;
endmodule : csfam_periph_model

// File: sim/tb.sv
// Purpose: self-checking bench for the status flag and address map core
// Assumes: 100 MHz clock, reset low two cycles
// Notes: random ops from a fixed seed plus corner cases
`timescale 1ns/1ps
module tb;
	logic                     clk_sys_i, rstn_i, vec_large_i, prog_en_i, pc_vld_o;
	csfam_pkg::csfam_ram_t    ram_size_i;
	csfam_pkg::csfam_rom_t    rom_size_i;
	csfam_pkg::csfam_bus_t    bus_i;
	csfam_pkg::csfam_req_t    op_i;
	csfam_pkg::csfam_region_t bus_region_o, er;
	csfam_pkg::csfam_peri_t   periph_o;
	csfam_pkg::csfam_res_t    res_o;
	logic [7:0]               periph_rdata_i, bus_rdata_o, ps_o, v, ep, msk;
	logic [15:0]              pc_o, a;
	int                       err_total, total_checks, cyc, k;
	logic [15:0] corners [22] = '{16'h0000, 16'h007F, 16'h0080, 16'h00BF, 16'h00C0, 16'h00FF,
		16'h0100, 16'h01BF, 16'h01C0, 16'hBFFF, 16'hC000, 16'hDFFF, 16'hE000, 16'hEFFF,
		16'hF000, 16'hFEFF, 16'hFF00, 16'hFFE7, 16'hFFE8, 16'hFFE9, 16'hFFEA, 16'hFFFF};
	// op codes with acc:m2; zero means random operands
	int          cop [14] = '{8, 0, 1, 6, 9, 7, 0, 12, 0, 1, 13, 11, 9, 10};
	logic [15:0] cval [14] = '{16'h0, 16'h7F01, 16'h8001, 16'h00C0, 16'h0, 16'h0, 16'h7F7F,
		16'h0, 16'h1929, 16'h1009, 16'h0, 16'h0, 16'h0, 16'h0};
	csfam_core csfam_core_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ram_size_i(ram_size_i),
		.rom_size_i(rom_size_i), .vec_large_i(vec_large_i), .prog_en_i(prog_en_i),
		.bus_i(bus_i), .periph_rdata_i(periph_rdata_i), .op_i(op_i), .bus_rdata_o(bus_rdata_o),
		.bus_region_o(bus_region_o), .periph_o(periph_o), .res_o(res_o), .ps_o(ps_o),
		.pc_o(pc_o), .pc_vld_o(pc_vld_o));
	csfam_periph_model csfam_periph_model_inst (.clk_sys_i(clk_sys_i), .bus_i(bus_i),
		.periph_o(periph_o), .periph_rdata_o(periph_rdata_i));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			err_total++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [15:0] ad, input logic [7:0] wd);
		@(posedge clk_sys_i);
		bus_i <= '{wr: w, rd: !w, addr: ad, wdata: wd};
		@(posedge clk_sys_i);
		bus_i <= '0;
		#1;
	endtask : bus
	function automatic csfam_pkg::csfam_region_t exp_reg(input logic [15:0] x);
		logic p, r, o;
		p = x inside {[16'h00C0:16'h00FF]};
		r = !p && (x <= 16'h007F || (ram_size_i != csfam_pkg::RAM_128 && x <= 16'h00BF)
			|| (ram_size_i == csfam_pkg::RAM_384 && x inside {[16'h0100:16'h01BF]}));
		o = x >= (rom_size_i == csfam_pkg::ROM_4K ? 16'hF000
			: rom_size_i == csfam_pkg::ROM_8K ? 16'hE000 : 16'hC000);
		return '{x <= 16'h00FF, x >= 16'hFF00, r, o, p, x >= (vec_large_i ? 16'hFFE8 : 16'hFFEA),
			!(p | r | o)};
	endfunction : exp_reg
	task automatic do_op(input int k, input logic [15:0] am);
		csfam_pkg::csfam_req_t q;
		logic [7:0] l, d, h;
		logic [8:0] s;
		q = {1'b1, 4'(k), 50'({$urandom, $urandom})};
		if (am != 16'h0)
			{q.acc, q.m1, q.m2} = {am[15:8], am};
		l = ep[5] ? q.m1 : q.acc;
		@(posedge clk_sys_i);
		op_i <= q;
		@(posedge clk_sys_i);
		op_i.vld <= 1'b0;
		#1;
		s = k[0] ? {1'b0, l} - q.m2 - !ep[0] : {1'b0, l} + q.m2 + ep[0];
		d = k == 2 ? l & q.m2 : k == 3 ? l | q.m2 : k == 4 ? l ^ q.m2 : k == 5 ? q.m2 : s[7:0];
		if (k <= 5)
		begin
			chk(res_o.to_mem, ep[5]);
			chk(res_o.waddr, ep[5] ? {8'h00, q.x} : 16'h0);
		end
		// decimal results leave flags meaningless until rewritten
		if (k < 2 && ep[3])
			msk = msk & 8'h3C;
		else if (k <= 5)
		begin
			chk(res_o.data, d);
			{ep[7], ep[1], msk} = {d[7], d == 8'h00, msk | 8'h82};
			if (k < 2)
				{ep[6], ep[0], msk} = {(l[7] ^ q.m2[7]) == k[0] && s[7] != l[7], s[8] ^ k[0],
					msk | 8'h41};
		end
		case (k)
			6: {ep[7:6], ep[1], msk} = {q.m2[7:6], (q.acc & q.m2) == 8'h00, msk | 8'hC2};
			7, 8: {ep[5], msk[5]} = {k == 7, 1'b1};
			9: {ep[6], msk[6]} = 2'b01;
			10, 11: {ep[0], msk[0]} = {k == 10, 1'b1};
			12, 13: ep[3] = k == 12;
			14, 15: ep[2] = k == 14;
			default: ;
		endcase
		chk(res_o.vld, 1'b1);
		chk(ps_o & msk, ep & msk);
		h = q.amode == csfam_pkg::AM_SPEC ? 8'hFF
			: q.amode == csfam_pkg::AM_ABS ? q.oper_hi : 8'h00;
		chk(res_o.ea, {h, q.oper_lo});
		chk(res_o.ilen, q.amode[0] ? 2'h3 : 2'h2);
	endtask : do_op
	task automatic finish_test();
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	initial
	begin
		void'($urandom(43486));
		{rstn_i, vec_large_i, prog_en_i, bus_i, op_i} = {3'b001, 26'h0, 55'h0};
		ram_size_i = csfam_pkg::RAM_384;
		rom_size_i = csfam_pkg::ROM_16K;
		{err_total, total_checks, cyc} = '0;
		{ep, msk} = {8'h04, 8'hDF};
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		#1;
		chk(ps_o & msk, ep);
		a = 16'($urandom);
		bus(1'b1, 16'hFFFE, a[7:0]);
		bus(1'b1, 16'hFFFF, a[15:8]);
		@(posedge clk_sys_i);
		prog_en_i <= 1'b0;
		for (int i = 0; i < 20 && pc_vld_o !== 1'b1; i++)
			@(posedge clk_sys_i);
		#1;
		chk(pc_vld_o, 1'b1);
		chk(pc_o, a);
		chk(ps_o[2], 1'b1);
		bus(1'b1, 16'hFFFE, ~a[7:0]);
		bus(1'b0, 16'hFFFE, 8'h00);
		chk(bus_rdata_o, a[7:0]);
		for (int c = 0; c < 18; c++)
		begin
			@(posedge clk_sys_i);
			ram_size_i <= csfam_pkg::csfam_ram_t'(c % 3);
			rom_size_i <= csfam_pkg::csfam_rom_t'(c / 3 % 3);
			vec_large_i <= c >= 9;
			for (int j = 0; j < 30; j++)
			begin
				a = j < 22 ? corners[j] : {j[0] ? 8'($urandom) : {7'h0, j[1]}, 8'($urandom)};
				v = 8'($urandom);
				bus(1'b1, a, v);
				bus(1'b0, a, 8'h00);
				er = exp_reg(a);
				chk(bus_region_o, er);
				if (!er.rom)
					chk(bus_rdata_o, er.unmapped ? 8'h00 : v);
			end
		end
		for (int i = 0; i < 14; i++)
			do_op(cop[i], cval[i]);
		repeat (300)
		begin
			k = $urandom_range(15, 0);
			do_op(k == 12 ? 13 : k, 16'h0);
		end
		finish_test();
	end
endmodule : tb
